// ===== include/t16wm_map.svh
`ifndef T16WM_MAP_SVH
`define T16WM_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define T16WM_OFS_CTRL_A 8'h80
`define T16WM_OFS_CTRL_B 8'h84
`define T16WM_OFS_CMP_A 8'h88
`define T16WM_OFS_CMP_B 8'h8c
`define T16WM_OFS_CAPTURE 8'h90
`define T16WM_OFS_COUNT 8'h94
`define T16WM_OFS_FLAGS 8'h98

// ****************************************
// Field positions
// ****************************************
`define T16WM_CA_ACT_A_MSB 7
`define T16WM_CA_ACT_A_LSB 6
`define T16WM_CA_ACT_B_MSB 5
`define T16WM_CA_ACT_B_LSB 4
`define T16WM_CA_WGM_MSB 1
`define T16WM_CA_WGM_LSB 0
`define T16WM_CB_WGM_MSB 4
`define T16WM_CB_WGM_LSB 3
`define T16WM_CB_CS_MSB 2
`define T16WM_CB_CS_LSB 0
`define T16WM_FLAG_OVF 0
`define T16WM_FLAG_CMP_A 1
`define T16WM_FLAG_CMP_B 2

// ****************************************
// Reset values
// ****************************************
`define T16WM_CTRL_A_RST 8'h00
`define T16WM_CTRL_B_RST 5'h00
`define T16WM_VALUE_RST 16'h0000

// ****************************************
// TOP values and prescaler terminal counts
// ****************************************
`define T16WM_TOP_MAX 16'hffff
`define T16WM_TOP_8BIT 16'h00ff
`define T16WM_TOP_9BIT 16'h01ff
`define T16WM_TOP_10BIT 16'h03ff
`define T16WM_DIV8_LAST 10'h007
`define T16WM_DIV64_LAST 10'h03f
`define T16WM_DIV256_LAST 10'h0ff
`define T16WM_DIV1024_LAST 10'h3ff

`endif

// ===== include/t16wm_pkg.sv
`default_nettype none
package t16wm_pkg;

   typedef enum logic [4:0] {
      T16WM_NORMAL = 5'b00001,
      T16WM_CTC = 5'b00010,
      T16WM_FAST = 5'b00100,
      T16WM_PC = 5'b01000,
      T16WM_PFC = 5'b10000
   } t16wm_kind_e;

   typedef enum logic [2:0] {
      T16WM_TOP_FIXED = 3'b001,
      T16WM_TOP_CMPA = 3'b010,
      T16WM_TOP_CAPT = 3'b100
   } t16wm_topsrc_e;

   typedef enum logic [2:0] {
      T16WM_CS_STOP = 3'h0,
      T16WM_CS_DIV1 = 3'h1,
      T16WM_CS_DIV8 = 3'h2,
      T16WM_CS_DIV64 = 3'h3,
      T16WM_CS_DIV256 = 3'h4,
      T16WM_CS_DIV1024 = 3'h5,
      T16WM_CS_EXT_FALL = 3'h6,
      T16WM_CS_EXT_RISE = 3'h7
   } t16wm_cs_e;

   typedef struct packed {
      t16wm_kind_e kind;
      t16wm_topsrc_e top_src;
      logic [15:0] fixed_top;
      logic reserved;
   } t16wm_mode_s;

   typedef struct packed {
      logic value;
      logic oe_n;
   } t16wm_pin_s;

endpackage
`default_nettype wire

// ===== hdl/t16wm_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "t16wm_map.svh"

module t16wm_prescale (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire t16wm_pkg::t16wm_cs_e clock_source_select_i,
   input wire logic ext_clk_i,
   output logic timer_tick_o
);
   import t16wm_pkg::*;

   logic [9:0] pre;
   logic ext_prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre <= 10'h000;
      end else begin
         pre <= pre + 10'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= ext_clk_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_tick_o <= 1'b0;
      end else begin
         case (clock_source_select_i)
            T16WM_CS_STOP: timer_tick_o <= 1'b0;
            T16WM_CS_DIV1: timer_tick_o <= 1'b1;
            T16WM_CS_DIV8: timer_tick_o <= (pre[2:0] == 3'(`T16WM_DIV8_LAST));
            T16WM_CS_DIV64: timer_tick_o <= (pre[5:0] == 6'(`T16WM_DIV64_LAST));
            T16WM_CS_DIV256: timer_tick_o <= (pre[7:0] == 8'(`T16WM_DIV256_LAST));
            T16WM_CS_DIV1024: timer_tick_o <= (pre == `T16WM_DIV1024_LAST);
            T16WM_CS_EXT_FALL: timer_tick_o <= ext_prev & ~ext_clk_i;
            T16WM_CS_EXT_RISE: timer_tick_o <= ~ext_prev & ext_clk_i;
            default: timer_tick_o <= 1'b0;
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== hdl/t16wm_timer.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "t16wm_map.svh"

module t16wm_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_clk_i,
   input wire logic [1:0] port_dir_i,
   input wire logic [1:0] port_val_i,
   output t16wm_pkg::t16wm_pin_s chan_a_pin_o,
   output t16wm_pkg::t16wm_pin_s chan_b_pin_o,
   output logic capture_enable_o
);
   import t16wm_pkg::*;

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic t16wm_mode_s decode_mode(input logic [3:0] wgm);
      t16wm_mode_s m;
      m.kind = T16WM_NORMAL;
      m.top_src = T16WM_TOP_FIXED;
      m.fixed_top = `T16WM_TOP_MAX;
      m.reserved = 1'b0;
      if (wgm[1:0] == 2'h1) begin
         m.fixed_top = `T16WM_TOP_8BIT;
      end else if (wgm[1:0] == 2'h2) begin
         m.fixed_top = `T16WM_TOP_9BIT;
      end else if (wgm[1:0] == 2'h3) begin
         m.fixed_top = `T16WM_TOP_10BIT;
      end
      case (wgm)
         4'h0: m.fixed_top = `T16WM_TOP_MAX;
         4'h1, 4'h2, 4'h3: m.kind = T16WM_PC;
         4'h4: begin
            m.kind = T16WM_CTC;
            m.top_src = T16WM_TOP_CMPA;
         end
         4'h5, 4'h6, 4'h7: m.kind = T16WM_FAST;
         4'h8: begin
            m.kind = T16WM_PFC;
            m.top_src = T16WM_TOP_CAPT;
         end
         4'h9: begin
            m.kind = T16WM_PFC;
            m.top_src = T16WM_TOP_CMPA;
         end
         4'ha: begin
            m.kind = T16WM_PC;
            m.top_src = T16WM_TOP_CAPT;
         end
         4'hb: begin
            m.kind = T16WM_PC;
            m.top_src = T16WM_TOP_CMPA;
         end
         4'hc: begin
            m.kind = T16WM_CTC;
            m.top_src = T16WM_TOP_CAPT;
         end
         4'he: begin
            m.kind = T16WM_FAST;
            m.top_src = T16WM_TOP_CAPT;
         end
         4'hf: begin
            m.kind = T16WM_FAST;
            m.top_src = T16WM_TOP_CMPA;
         end
         default: begin
            m.fixed_top = `T16WM_TOP_MAX;
            m.reserved = 1'b1;
         end
      endcase
      return m;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction

   // ****************************************
   // State
   // ****************************************
   logic [7:0] timer_output_and_wave_mode_ctrl;
   logic [4:0] timer_clock_and_capture_ctrl;
   logic [1:0][15:0] cmp_buf;
   logic [1:0][15:0] cmp_act;
   logic [15:0] capture_value;
   logic [15:0] count;
   logic count_down;
   logic [2:0] flags;
   logic [1:0] wave;
   t16wm_pin_s [1:0] pin_q;
   logic timer_tick;
   logic [3:0] waveform_mode;
   t16wm_mode_s mode;
   logic [15:0] top;
   logic at_top;
   logic at_bottom;
   logic dual;
   logic req;
   logic wr;
   logic count_wr;
   logic ovf_evt;
   logic upd_evt;
   logic [1:0] match;
   logic [1:0] connected;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [31:0] rd_data;

   t16wm_prescale u_prescale (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clock_source_select_i(t16wm_cs_e'(timer_clock_and_capture_ctrl[`T16WM_CB_CS_MSB:
                                                                     `T16WM_CB_CS_LSB])),
      .ext_clk_i(ext_clk_i),
      .timer_tick_o(timer_tick)
   );

   assign waveform_mode = {timer_clock_and_capture_ctrl[`T16WM_CB_WGM_MSB:`T16WM_CB_WGM_LSB],
                           timer_output_and_wave_mode_ctrl[`T16WM_CA_WGM_MSB:`T16WM_CA_WGM_LSB]};
   assign mode = decode_mode(waveform_mode);
   assign dual = (mode.kind == T16WM_PC) || (mode.kind == T16WM_PFC);

   always_comb begin
      case (mode.top_src)
         T16WM_TOP_CMPA: top = cmp_act[0];
         T16WM_TOP_CAPT: top = capture_value;
         default: top = mode.fixed_top;
      endcase
   end

   assign at_top = (count == top);
   assign at_bottom = (count == `T16WM_VALUE_RST);

   // ****************************************
   // Wishbone slave
   // ****************************************
   assign req = wb_cyc_i & wb_stb_i;
   assign wr = req & wb_ack_o & wb_we_i;
   assign count_wr = wr && (wb_adr_i == `T16WM_OFS_COUNT);

   always_comb begin
      case (wb_adr_i)
         `T16WM_OFS_CTRL_A: rd_data = {24'h000000, timer_output_and_wave_mode_ctrl};
         `T16WM_OFS_CTRL_B: rd_data = {27'h0000000, timer_clock_and_capture_ctrl};
         `T16WM_OFS_CMP_A: rd_data = {16'h0000, cmp_buf[0]};
         `T16WM_OFS_CMP_B: rd_data = {16'h0000, cmp_buf[1]};
         `T16WM_OFS_CAPTURE: rd_data = {16'h0000, capture_value};
         `T16WM_OFS_COUNT: rd_data = {16'h0000, count};
         `T16WM_OFS_FLAGS: rd_data = {29'h00000000, flags};
         default: rd_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_output_and_wave_mode_ctrl <= `T16WM_CTRL_A_RST;
         timer_clock_and_capture_ctrl <= `T16WM_CTRL_B_RST;
         capture_value <= `T16WM_VALUE_RST;
      end else if (wr && wb_sel_i[0]) begin
         if (wb_adr_i == `T16WM_OFS_CTRL_A) begin
            timer_output_and_wave_mode_ctrl <= {wb_dat_i[7:4], 2'b00, wb_dat_i[1:0]};
         end
         if (wb_adr_i == `T16WM_OFS_CTRL_B) begin
            timer_clock_and_capture_ctrl <= wb_dat_i[4:0];
         end
         if (wb_adr_i == `T16WM_OFS_CAPTURE) begin
            capture_value <= merge16(capture_value, wb_dat_i, wb_sel_i);
         end
      end else if (wr && (wb_adr_i == `T16WM_OFS_CAPTURE)) begin
         capture_value <= merge16(capture_value, wb_dat_i, wb_sel_i);
      end
   end

   // Capture off while it defines TOP
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_enable_o <= 1'b1;
      end else begin
         capture_enable_o <= (mode.top_src != T16WM_TOP_CAPT);
      end
   end

   // ****************************************
   // Counter and timing events
   // ****************************************
   // Counter moves only on the tick enable or on a bus write to COUNT
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= `T16WM_VALUE_RST;
         count_down <= 1'b0;
      end else if (count_wr) begin
         count <= merge16(count, wb_dat_i, wb_sel_i);
      end else if (timer_tick) begin
         if (!dual) begin
            count <= at_top ? `T16WM_VALUE_RST : count + 16'h0001;
            count_down <= 1'b0;
         end else if (at_top && !at_bottom) begin
            count <= count - 16'h0001;
            count_down <= 1'b1;
         end else if (at_bottom) begin
            count <= count + 16'h0001;
            count_down <= 1'b0;
         end else begin
            count <= count_down ? count - 16'h0001 : count + 16'h0001;
         end
      end
   end

   always_comb begin
      case (mode.kind)
         T16WM_FAST: begin
            ovf_evt = timer_tick & at_top;
            upd_evt = timer_tick & at_bottom;
         end
         T16WM_PC: begin
            ovf_evt = timer_tick & at_bottom;
            upd_evt = timer_tick & at_top;
         end
         T16WM_PFC: begin
            ovf_evt = timer_tick & at_bottom;
            upd_evt = timer_tick & at_bottom;
         end
         default: begin
            ovf_evt = timer_tick & (count == `T16WM_TOP_MAX);
            upd_evt = 1'b1;
         end
      endcase
   end

   // ****************************************
   // Compare channels
   // ****************************************
   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic [1:0] act;
      logic toggle_ok;
      assign act = (i == 0) ?
         timer_output_and_wave_mode_ctrl[`T16WM_CA_ACT_A_MSB:`T16WM_CA_ACT_A_LSB] :
         timer_output_and_wave_mode_ctrl[`T16WM_CA_ACT_B_MSB:`T16WM_CA_ACT_B_LSB];
      assign match[i] = timer_tick & (count == cmp_act[i]);

      always_comb begin
         case (mode.kind)
            T16WM_FAST: toggle_ok = (i == 0) && waveform_mode[3:1] == 3'h7;
            T16WM_PC, T16WM_PFC: toggle_ok = (i == 0) && (waveform_mode == 4'h9 ||
                                                          waveform_mode == 4'hb);
            default: toggle_ok = 1'b1;
         endcase
      end

      assign connected[i] = (act != 2'b00) && !mode.reserved && (act[1] || toggle_ok);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cmp_buf[i] <= `T16WM_VALUE_RST;
         end else if (wr && wb_adr_i == ((i == 0) ? `T16WM_OFS_CMP_A : `T16WM_OFS_CMP_B)) begin
            cmp_buf[i] <= merge16(cmp_buf[i], wb_dat_i, wb_sel_i);
         end
      end

      // Buffered value loads at the update point
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cmp_act[i] <= `T16WM_VALUE_RST;
         end else if (upd_evt) begin
            cmp_act[i] <= cmp_buf[i];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            wave[i] <= 1'b0;
         end else if (connected[i]) begin
            case (mode.kind)
               T16WM_FAST: begin
                  // Set/clear match ignored when compare is TOP; toggle still acts on it
                  if (!act[1]) begin
                     wave[i] <= match[i] ? ~wave[i] : wave[i];
                  end else if (match[i] && cmp_act[i] != top) begin
                     wave[i] <= act[0];
                  end else if (timer_tick && at_bottom) begin
                     wave[i] <= ~act[0];
                  end
               end
               T16WM_PC, T16WM_PFC: begin
                  if (match[i]) begin
                     wave[i] <= !act[1] ? ~wave[i] : (act[0] ^ count_down);
                  end
               end
               default: begin
                  if (match[i]) begin
                     wave[i] <= (act == 2'b01) ? ~wave[i] : act[0];
                  end
               end
            endcase
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pin_q[i] <= '{value: 1'b0, oe_n: 1'b1};
         end else begin
            pin_q[i].value <= connected[i] ? wave[i] : port_val_i[i];
            pin_q[i].oe_n <= ~port_dir_i[i];
         end
      end
   end

   assign chan_a_pin_o = pin_q[0];
   assign chan_b_pin_o = pin_q[1];

   // ****************************************
   // Flags
   // ****************************************
   assign flag_set = {match[1], match[0], ovf_evt};
   assign flag_clr = (wr && wb_sel_i[0] && wb_adr_i == `T16WM_OFS_FLAGS) ? wb_dat_i[2:0] : 3'h0;

   // Set on the edge ending the tick; set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 3'h0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_resv_zero: assert property (timer_output_and_wave_mode_ctrl[3:2] == 2'b00)
      else $error("reserved control bits not zero");
   chk_count_hold: assert property (!timer_tick && !count_wr |=> $stable(count))
      else $error("counter moved without tick");
   chk_cmp_flag: assert property (timer_tick && count == cmp_act[0]
      |=> flags[`T16WM_FLAG_CMP_A])
      else $error("compare A flag not set after match");
   chk_ovf_max: assert property (timer_tick && !count_wr && mode.kind == T16WM_NORMAL
      && count == `T16WM_TOP_MAX |=> flags[`T16WM_FLAG_OVF] && count == 16'h0000)
      else $error("normal mode overflow wrong");
   chk_fixed_top: assert property (waveform_mode == 4'h2 |-> top == `T16WM_TOP_9BIT)
      else $error("fixed 9-bit top wrong");
   chk_pfc_update: assert property (mode.kind == T16WM_PFC && timer_tick && at_bottom
      |=> cmp_act[1] == $past(cmp_buf[1]))
      else $error("buffered compare not loaded at bottom");
   chk_capture_off: assert property (mode.top_src == T16WM_TOP_CAPT
      |=> !capture_enable_o)
      else $error("capture still enabled");
   chk_pin_dir: assert property (!rst_i |=> pin_q[0].oe_n == !$past(port_dir_i[0]))
      else $error("driver enable does not follow direction");
   chk_resv_mode: assert property (waveform_mode == 4'hd
      |=> pin_q[1].value == $past(port_val_i[1]))
      else $error("reserved mode drives wave");
   chk_fast_bottom: assert property (connected[0] && mode.kind == T16WM_FAST
      && timer_output_and_wave_mode_ctrl[7:6] == 2'b10 && timer_tick && at_bottom
      && !match[0] |=> wave[0])
      else $error("non-inverting output not set at bottom");

   cov_fast_pwm: cover property (mode.kind == T16WM_FAST && connected[0] && match[0]);
   cov_dual_down: cover property (dual && count_down && match[1]);
   cov_flag_race: cover property (flag_set[0] && flag_clr[0]);

endmodule
`default_nettype wire

// ===== verif/t16wm_load.sv
`timescale 1ns/1ps
`default_nettype none
module t16wm_load (
   input wire logic clk_i,
   input wire t16wm_pkg::t16wm_pin_s pin_i,
   output logic level_o
);
   import t16wm_pkg::*;
   logic last_driven;
   // ****************************************
   // Released pin shows the inverse of its last driven level
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!pin_i.oe_n) begin
         last_driven <= pin_i.value;
      end
   end
   assign level_o = pin_i.oe_n ? ~last_driven : pin_i.value;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import t16wm_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ext_clk, ack, cap_en, lvl_a, lvl_b;
   logic [7:0] adr;
   logic [31:0] dat, rdat;
   logic [1:0] dir, pval;
   t16wm_pin_s pin_a, pin_b;
   int failures, num_checks, seed, hi, lo, n, x;
   logic [31:0] expq[$];
   logic [2:0] cst[5] = '{3'h1, 3'h2, 3'h7, 3'h3, 3'h6};
   int dv[5] = '{1, 8, 8, 64, 8};
   logic [3:0] md[4] = '{4'd0, 4'd5, 4'd10, 4'd13};
   logic [3:0] ac[4] = '{4'h0, 4'h5, 4'h5, 4'hf};
   t16wm_timer t16wm_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk_i(ext_clk), .port_dir_i(dir),
      .port_val_i(pval), .chan_a_pin_o(pin_a), .chan_b_pin_o(pin_b),
      .capture_enable_o(cap_en));
   t16wm_load load_a_i (.clk_i(clk_i), .pin_i(pin_a), .level_o(lvl_a));
   t16wm_load load_b_i (.clk_i(clk_i), .pin_i(pin_b), .level_o(lvl_b));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      ext_clk = 1'b0;
      forever begin
         repeat (4) @(posedge clk_i);
         ext_clk <= ~ext_clk;
      end
   end
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tmo();
      failures++;
      conclude();
   endtask
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) chk("rdata", expq.pop_front(), rdat);
   end
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) tmo();
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      expq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic run(logic [3:0] m, logic [3:0] act, logic [2:0] cs);
      wb(1'b1, 8'h84, 32'h0);
      wb(1'b1, 8'h94, 32'h0);
      wb(1'b1, 8'h80, {24'h0, act, 2'b00, m[1:0]});
      wb(1'b1, 8'h84, {27'h0, m[3:2], cs});
   endtask
   task automatic span(logic b, logic v, output int c);
      c = 0;
      while ((b ? lvl_b : lvl_a) === v && c < 3000) begin
         @(posedge clk_i);
         c++;
      end
      if (c >= 3000) tmo();
   endtask
   task automatic measure(logic b);
      int z;
      repeat (2) begin
         span(b, 1'b1, z);
         span(b, 1'b0, z);
         span(b, 1'b1, hi);
         span(b, 1'b0, lo);
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 86;
      failures = 0;
      num_checks = 0;
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      dir = 2'b11;
      pval = 2'b00;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h80, 32'h0);
      wb(1'b1, 8'h80, 32'hff);
      rd(8'h80, 32'hf3);
      rd(8'hfc, 32'h0);
      for (int i = 0; i < 4; i++) begin
         pval <= 2'($random(seed));
         dir <= 2'($random(seed));
         run(md[i], ac[i], 3'h1);
         repeat (3) @(posedge clk_i);
         chk("pin_a", {30'h0, pval[0], ~dir[0]}, {30'h0, pin_a});
         chk("pin_b", {30'h0, pval[1], ~dir[1]}, {30'h0, pin_b});
      end
      dir <= 2'b11;
      for (int i = 0; i < 5; i++) begin
         n = 3 + ($random(seed) & 7);
         wb(1'b1, 8'h88, 32'(n));
         run(4'd4, 4'b0100, cst[i]);
         measure(1'b0);
         chk("ctc_hi", 32'((n + 1) * dv[i]), 32'(hi));
         chk("ctc_lo", 32'((n + 1) * dv[i]), 32'(lo));
      end
      chk("cap_en", 32'h1, {31'h0, cap_en});
      wb(1'b1, 8'h90, 32'h9);
      wb(1'b1, 8'h88, 32'h3);
      wb(1'b1, 8'h8c, 32'h6);
      run(4'd14, 4'b1011, 3'h1);
      measure(1'b0);
      chk("fast_a", 32'h3, 32'(hi));
      measure(1'b1);
      chk("fast_b", 32'h6, 32'(lo));
      chk("cap_en", 32'h0, {31'h0, cap_en});
      wb(1'b1, 8'h88, 32'h9);
      repeat (30) @(posedge clk_i);
      x = 0;
      repeat (60) begin
         @(posedge clk_i);
         if (lvl_a !== 1'b1) x++;
      end
      chk("steady", 32'h0, 32'(x));
      dir <= 2'b10;
      repeat (2) @(posedge clk_i);
      chk("oe_a", 32'h1, {31'h0, pin_a.oe_n});
      dir <= 2'b11;
      wb(1'b1, 8'h88, 32'd200);
      run(4'd1, 4'b1000, 3'h1);
      measure(1'b0);
      chk("pc_hi", 32'd400, 32'(hi));
      chk("pc_lo", 32'd110, 32'(lo));
      for (int i = 9; i < 12; i += 2) begin
         wb(1'b1, 8'h88, 32'd20);
         run(4'(i), 4'b0100, 3'h1);
         measure(1'b0);
         chk("dual_tog", 32'd40, 32'(hi));
      end
      run(4'd0, 4'h0, 3'h0);
      wb(1'b1, 8'h88, 32'h2);
      wb(1'b1, 8'h98, 32'h7);
      rd(8'h98, 32'h0);
      wb(1'b1, 8'h84, 32'h1);
      repeat (10) @(posedge clk_i);
      wb(1'b1, 8'h84, 32'h0);
      rd(8'h98, 32'h6);
      conclude();
   end
endmodule
`default_nettype wire
